// ---- core/bctu_pkg.sv ----
package bctu_pkg;

  // Instruction field positions
  localparam int OpHi = 23;
  localparam int OpLo = 18;
  localparam int SubHi = 17;
  localparam int SubLo = 12;
  localparam int AddrHi = 14;
  localparam int PageModBit = 11;
  localparam int ReturnKeyCount = 6;

  // Major operation codes
  localparam logic [5:0] OpJumpKey = 6'h00;
  localparam logic [5:0] OpAlways = 6'h01;
  localparam logic [5:0] OpIndexJmp = 6'h02;
  localparam logic [5:0] OpCompare = 6'h03;
  localparam logic [5:0] OpDecimal = 6'h38;
  localparam logic [5:0] OpTransfer = 6'h3F;

  // Sub codes of the transfer group
  localparam logic [5:0] SubChanRead = 6'h2D;
  localparam logic [5:0] SubPageWrite = 6'h2E;
  localparam logic [5:0] SubPageRead = 6'h2F;
  localparam logic [5:0] SubCondGrp = 6'h33;
  localparam logic [5:0] SubLastJump = 6'h36;

  // Condition flag bit positions
  localparam int CfBoundary = 0;
  localparam int CfDestLoad = 1;
  localparam int CfOperReloc = 2;
  localparam int CfStateJump = 3;
  localparam int CfIntEnable = 4;
  localparam int CfProgState = 5;
  localparam logic [5:0] CondFlagsReset = 6'h00;

  // One's complement constants
  localparam logic [14:0] IdxPosZero = 15'h0000;
  localparam logic [14:0] IdxNegZero = 15'h7FFF;
  localparam logic [14:0] IdxOne = 15'h0001;

  // Compare selectors
  localparam logic [1:0] CmpEq = 2'h0;
  localparam logic [1:0] CmpNe = 2'h1;
  localparam logic [1:0] CmpGe = 2'h2;
  localparam logic [1:0] CmpLt = 2'h3;

  // Decimal result variants
  localparam logic [2:0] DecHigh = 3'h0;
  localparam logic [2:0] DecZero = 3'h1;
  localparam logic [2:0] DecLow = 3'h2;

  // Sequencer states
  typedef enum logic [1:0] {
    BCTU_IDLE = 2'b00,
    BCTU_PAGE = 2'b01,
    BCTU_DONE = 2'b10
  } bctu_state_type;

  // Instruction issued by the sequencing path
  typedef struct packed {
    logic valid;
    logic [23:0] word;
    logic [14:0] addr;
    logic [14:0] idxAddr;
    logic progState;
  } bctu_instr_type;

  // Completion answer to the sequencing path
  typedef struct packed {
    logic done;
    logic taken;
    logic trap;
    logic [14:0] target;
    logic accWe;
    logic [23:0] accData;
    logic idxWe;
    logic [1:0] idxSel;
    logic [14:0] idxData;
  } bctu_result_type;

endpackage

// ---- core/bctu_page_mem.sv ----
`timescale 1ns/1ps
module bctu_page_mem
  import bctu_pkg::*;
#(
  parameter int AddrWidth = 7,
  parameter int DataWidth = 12
) (
  input wire logic clock,
  input wire logic clockEnable,
  input wire logic writeEn,
  input wire logic [AddrWidth-1:0] addr,
  input wire logic [DataWidth-1:0] writeData,
  output logic [DataWidth-1:0] readData
);

  // Storage array, no reset: contents are software owned
  logic [DataWidth-1:0] mem [2**AddrWidth];

  // Synchronous write and registered read
  always_ff @(posedge clock) begin
    if (clockEnable) begin
      if (writeEn) begin
        mem[addr] <= writeData;
      end
      readData <= mem[addr];
    end
  end

endmodule

// ---- core/bctu_ones_add.sv ----
`timescale 1ns/1ps
module bctu_ones_add
  import bctu_pkg::*;
(
  input wire logic [14:0] value,
  input wire logic down,
  output logic [14:0] result
);

  // Sum with end-around carry; negative zero never produced
  logic [15:0] sum;

  always_comb begin
    if (down) begin
      // Subtract one as add of 77776
      sum = {1'b0, value} + {1'b0, ~IdxOne};
    end else begin
      sum = {1'b0, value} + {1'b0, IdxOne};
    end
    result = sum[14:0] + {14'h0000, sum[15]};
    // Minus zero folds to plus zero (77776 + 1 and 00001 - 1)
    // Without the fold a down count from one would reach minus zero and keep jumping
    if (result == IdxNegZero) begin
      result = IdxPosZero;
    end
  end

endmodule

// ---- core/bctu_core.sv ----
`timescale 1ns/1ps
// What this block does
// - Channel index read copies into acc 00-02
// - Page write stores acc 00-11 at w
// - Page read loads entry w into acc
// - Bit 11 adds index two to w
// - Page transfers are no-ops without option
// - Flag read copies flags, then clears them
// - Interrupts held off until flag read
// - Flag bits: boundary, load, reloc, jump, int, state
// - Flag write loads flags from acc 00-05
// - After flag write, interrupts off until jump
// - Record program-state jump address, readable
// - Jump key j set branches to m
// - Unconditional jump always goes to M
// - Decimal result tests branch per variant
// - Trap result tests without decimal processor
// - Up index jump: zero falls, else increment
// - Index register zero makes no-operation
// - Increment never makes negative zero
// - Down index jump: zero falls, else decrement
// - Negative zero counts down whole range
// - Zero compare branches on j condition
// - Both zeros equal; minus zero below plus
module bctu_core
  import bctu_pkg::*;
#(
  parameter int PageAddrWidth = 7
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clockEnable,
  input wire bctu_instr_type instr,
  input wire logic [23:0] acc,
  input wire logic [14:0] idx1,
  input wire logic [14:0] idx2,
  input wire logic [14:0] idx3,
  input wire logic [2:0] channelIndex,
  input wire logic [ReturnKeyCount-1:0] jumpKeys,
  input wire logic [2:0] decimalFlags,
  input wire logic decimalPresent,
  input wire logic decimalEnable,
  input wire logic multiprogPresent,
  input wire logic interruptTaken,
  input wire logic [5:0] condEvents,
  output bctu_result_type result,
  output logic [5:0] conditionFlags,
  output logic [14:0] lastJumpAddr,
  output logic interruptHold
);

  ////////////////////////////////////////////////////////////////
  // State
  ////////////////////////////////////////////////////////////////

  // All module state in one record
  typedef struct packed {
    bctu_state_type state;
    logic [5:0] flags;
    logic [14:0] lastJump;
    logic holdRecog;
    logic holdRestore;
    logic [5:0] keySync1;
    logic [5:0] keySync2;
    logic [2:0] decSync1;
    logic [2:0] decSync2;
    logic [1:0] swSync1;
    logic [1:0] swSync2;
    bctu_result_type res;
  } bctu_regs_type;

  bctu_regs_type r_q;
  bctu_regs_type r_d;

  // Decoded fields
  logic [5:0] opCode;
  logic [5:0] subCode;
  logic [2:0] jField;
  logic [1:0] bField;
  logic indexDown;
  logic [14:0] mAddr;
  logic [14:0] selIdx;
  logic [14:0] stepped;
  logic [PageAddrWidth-1:0] pageAddr;
  logic pageWe;
  logic [11:0] pageRd;
  logic accNegZero;
  logic accPosZero;
  logic cmpHit;
  logic isTransfer;
  logic isJumpType;

  assign opCode = instr.word[OpHi:OpLo];
  assign subCode = instr.word[SubHi:SubLo];
  assign jField = instr.word[17:15];
  assign bField = instr.word[16:15];
  assign indexDown = instr.word[17];
  assign mAddr = instr.word[AddrHi:0];
  assign isTransfer = (opCode == OpTransfer);

  ////////////////////////////////////////////////////////////////
  // Helpers
  ////////////////////////////////////////////////////////////////

  // Index register chosen by b; zero selects nothing
  always_comb begin
    case (bField)
      2'd1: selIdx = idx1;
      2'd2: selIdx = idx2;
      2'd3: selIdx = idx3;
      default: selIdx = IdxPosZero;
    endcase
  end

  // One's complement stepper for index jumps
  bctu_ones_add u_step (
    .value(selIdx),
    .down(indexDown),
    .result(stepped)
  );

  // Page entry address, optionally modified by index two
  always_comb begin
    if (instr.word[PageModBit]) begin
      pageAddr = PageAddrWidth'(instr.word[PageAddrWidth-1:0] + idx2[PageAddrWidth-1:0]);
    end else begin
      pageAddr = instr.word[PageAddrWidth-1:0];
    end
  end

  // Write only when idle and the option exists
  assign pageWe = r_q.state == BCTU_IDLE && instr.valid && isTransfer && subCode == SubPageWrite
    && !instr.word[PageModBit - 4] && multiprogPresent;

  // Page index file storage
  bctu_page_mem #(
    .AddrWidth(PageAddrWidth),
    .DataWidth(12)
  ) u_page (
    .clock(clock),
    .clockEnable(clockEnable),
    .writeEn(pageWe),
    .addr(pageAddr),
    .writeData(acc[11:0]),
    .readData(pageRd)
  );

  // Accumulator zero forms
  assign accPosZero = (acc == 24'h00_0000);
  assign accNegZero = (acc == 24'hFF_FFFF);

  // Zero compare condition
  always_comb begin
    case (instr.word[16:15])
      CmpEq: cmpHit = accPosZero || accNegZero;
      CmpNe: cmpHit = !(accPosZero || accNegZero);
      CmpGe: cmpHit = !acc[23];
      default: cmpHit = acc[23];
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////

  always_comb begin
    r_d = r_q;
    isJumpType = 1'b0;
    // Synchronisers for console and pin levels
    r_d.keySync1 = jumpKeys;
    r_d.keySync2 = r_q.keySync1;
    r_d.decSync1 = decimalFlags;
    r_d.decSync2 = r_q.decSync1;
    r_d.swSync1 = {decimalPresent, decimalEnable};
    r_d.swSync2 = r_q.swSync1;
    // Result pulses clear by default
    r_d.res = '0;
    r_d.res.target = instr.addr + 15'h0001;
    case (r_q.state)
      BCTU_IDLE: begin
        if (instr.valid) begin
          r_d.res.done = 1'b1;
          case (opCode)
            OpJumpKey: begin
              isJumpType = 1'b1;
              // Key numbers 1..6; zero never matches
              if (jField != 3'd0 && jField != 3'd7 && r_q.keySync2[jField - 3'd1]) begin
                r_d.res.taken = 1'b1;
                r_d.res.target = mAddr;
              end
            end
            OpAlways: begin
              isJumpType = 1'b1;
              r_d.res.taken = 1'b1;
              r_d.res.target = instr.idxAddr;
            end
            OpIndexJmp: begin
              isJumpType = 1'b1;
              // Register zero or plus zero falls through
              if (bField != 2'd0 && selIdx != IdxPosZero) begin
                r_d.res.taken = 1'b1;
                r_d.res.target = mAddr;
                r_d.res.idxWe = 1'b1;
                r_d.res.idxSel = bField;
                r_d.res.idxData = stepped;
              end
            end
            OpCompare: begin
              isJumpType = 1'b1;
              // Only the zero variant lives here
              if (!instr.word[17] && cmpHit) begin
                r_d.res.taken = 1'b1;
                r_d.res.target = mAddr;
              end
            end
            OpDecimal: begin
              isJumpType = 1'b1;
              // Missing or disabled processor traps
              if (!(r_q.swSync2[1] && r_q.swSync2[0])) begin
                r_d.res.trap = 1'b1;
              end else if ((jField == DecHigh && r_q.decSync2[0])
                  || (jField == DecZero && r_q.decSync2[1])
                  || (jField == DecLow && r_q.decSync2[2])) begin
                r_d.res.taken = 1'b1;
                r_d.res.target = mAddr;
              end
            end
            OpTransfer: begin
              if (subCode == SubChanRead) begin
                r_d.res.accWe = 1'b1;
                r_d.res.accData = {21'h00_0000, channelIndex};
              end else if (subCode == SubPageWrite && instr.word[PageModBit - 4] == 1'b0) begin
                r_d.res.done = 1'b1;
              end else if (subCode == SubPageWrite) begin
                // Read waits one cycle for the memory
                if (multiprogPresent) begin
                  r_d.res.done = 1'b0;
                  r_d.state = BCTU_PAGE;
                end
              end else if (subCode == SubCondGrp && !instr.word[11]) begin
                r_d.res.accWe = 1'b1;
                r_d.res.accData = {18'h0_0000, r_q.flags};
                r_d.flags = CondFlagsReset | condEvents;
                r_d.holdRecog = 1'b0;
              end else if (subCode == SubCondGrp) begin
                r_d.flags = acc[5:0];
                r_d.holdRestore = 1'b1;
              end else if (subCode == SubLastJump) begin
                r_d.res.accWe = 1'b1;
                r_d.res.accData = {9'h000, r_q.lastJump};
              end
            end
            default: r_d.res.done = 1'b0;
          endcase
          // Record program-state jumps; exit ends restore hold
          if (isJumpType && instr.progState) begin
            r_d.lastJump = instr.addr;
          end
          if (isJumpType) begin
            r_d.holdRestore = 1'b0;
          end
        end
      end
      BCTU_PAGE: begin
        r_d.res.done = 1'b1;
        r_d.res.accWe = 1'b1;
        r_d.res.accData = {12'h000, pageRd};
        r_d.state = BCTU_IDLE;
      end
      default: r_d.state = BCTU_IDLE;
    endcase
    // Recognition opens the hold window; it wins over a same-cycle flag read
    if (interruptTaken) begin
      r_d.holdRecog = 1'b1;
    end
    // Hardware events set flags; they win over a write
    r_d.flags = r_d.flags | condEvents;
  end

  ////////////////////////////////////////////////////////////////
  // Registers
  ////////////////////////////////////////////////////////////////

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      r_q <= '0;
    end else if (clockEnable) begin
      r_q <= r_d;
    end
  end

  // Outputs
  assign result = r_q.res;
  assign conditionFlags = r_q.flags;
  assign lastJumpAddr = r_q.lastJump;
  assign interruptHold = r_q.holdRecog || r_q.holdRestore;

endmodule

// ---- test/bctu_checker.sv ----
`timescale 1ns/1ps
module bctu_checker
  import bctu_pkg::*;
#(
  parameter int PageAddrWidth = 7
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic clockEnable,
  input wire bctu_instr_type instr,
  input wire logic [23:0] acc,
  input wire logic [14:0] idx1,
  input wire logic [14:0] idx2,
  input wire logic [14:0] idx3,
  input wire logic [2:0] channelIndex,
  input wire logic interruptTaken,
  input wire logic [5:0] condEvents,
  input wire bctu_result_type result,
  input wire logic [5:0] conditionFlags,
  input wire logic [14:0] lastJumpAddr,
  input wire logic interruptHold
);
  ////////////////////////////////////////////////////////////
  // Request decode, only meaningful while a request is offered
  logic take;
  logic [5:0] op;
  logic [14:0] selIdx;
  logic [14:0] pAddr;
  logic [14:0] mAddr;
  logic [5:0] accLow;
  logic isCond;
  logic hit;
  assign take = instr.valid && clockEnable;
  assign op = instr.word[OpHi:OpLo];
  assign pAddr = instr.addr;
  assign mAddr = instr.idxAddr;
  assign accLow = acc[5:0];
  // Flag events excluded: set wins over the clear or load
  assign isCond = take && op == OpTransfer && instr.word[SubHi:SubLo] == SubCondGrp && condEvents == 6'h00;
  // Designator zero reads as zero so it always falls through
  always_comb begin
    case (instr.word[16:15])
      2'h1: selIdx = idx1;
      2'h2: selIdx = idx2;
      2'h3: selIdx = idx3;
      default: selIdx = IdxPosZero;
    endcase
  end
  // Both zero encodings equal zero; sign alone orders them
  always_comb begin
    hit = (acc == 24'h00_0000) || (acc == 24'hff_ffff);
    case (instr.word[16:15])
      2'h1: hit = !hit;
      2'h2: hit = !acc[23];
      2'h3: hit = acc[23];
      default: ;
    endcase
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  chan_copy_a: assert property (take && op == OpTransfer && instr.word[SubHi:SubLo] == SubChanRead
    |=> result.accWe && result.accData[2:0] == $past(channelIndex)) else $error("channel index not copied");
  always_go_a: assert property (take && op == OpAlways
    |=> result.taken && result.target == $past(mAddr)) else $error("unconditional target wrong");
  last_jump_a: assert property (take && op == OpAlways && instr.progState
    |-> ##2 lastJumpAddr == $past(pAddr, 2)) else $error("last jump address not kept");
  zero_cmp_a: assert property (take && op == OpCompare && !instr.word[17]
    |=> result.taken == $past(hit)) else $error("zero compare decision wrong");
  idx_none_a: assert property (take && op == OpIndexJmp && instr.word[16:15] == 2'h0
    |=> !result.taken && !result.idxWe) else $error("index zero not a no-op");
  idx_fall_a: assert property (take && op == OpIndexJmp && selIdx == IdxPosZero
    |=> !result.taken && result.target == $past(pAddr) + 15'h0001) else $error("zero index did not fall");
  idx_wrap_a: assert property (take && op == OpIndexJmp && !instr.word[17] && selIdx == IdxNegZero
    |=> result.idxWe && result.idxData == IdxOne) else $error("minus zero increment wrong");
  idx_down_a: assert property (take && op == OpIndexJmp && instr.word[17] && selIdx != IdxPosZero
    |=> result.taken && result.idxData == $past(selIdx) - 15'h0001) else $error("decrement wrong");
  flag_clear_a: assert property (isCond && !instr.word[PageModBit]
    |=> conditionFlags == 6'h00 && result.accData[5:0] == $past(conditionFlags)) else $error("flag read wrong");
  flag_load_a: assert property (isCond && instr.word[PageModBit]
    |=> conditionFlags == $past(accLow) ##1 interruptHold) else $error("flag write wrong");
  irq_hold_a: assert property (interruptTaken && !take
    |=> interruptHold [*2]) else $error("interrupts not held off");
endmodule

bind bctu_core bctu_checker #(.PageAddrWidth(PageAddrWidth)) chkInst (.clock(clock), .arst_n(arst_n),
  .clockEnable(clockEnable), .instr(instr), .acc(acc), .idx1(idx1), .idx2(idx2), .idx3(idx3),
  .channelIndex(channelIndex), .interruptTaken(interruptTaken), .condEvents(condEvents), .result(result),
  .conditionFlags(conditionFlags), .lastJumpAddr(lastJumpAddr), .interruptHold(interruptHold));

// ---- test/tb.sv ----
`timescale 1ns/1ps
module tb;
  import bctu_pkg::*;
  ////////////////////////////////////////////////////////////
  // Drives, all valued at time zero
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  bctu_instr_type instr = '0;
  logic [23:0] acc = '0;
  logic [14:0] idx1 = '0, idx2 = '0, idx3 = '0;
  logic [2:0] chan = '0, dflags = '0;
  logic [5:0] keys = '0, events = '0;
  logic dPres = 1'b1, dEn = 1'b1, mpPres = 1'b1, irq = 1'b0;
  bctu_result_type result;
  logic [5:0] flags;
  logic [14:0] lastJump;
  logic hold;
  int fails = 0, checks_done = 0;
  logic [14:0] corner [5] = '{15'h0000, 15'h0001, 15'h7ffe, 15'h7fff, 15'h2345};
  logic [23:0] accCorner [5] = '{24'h00_0000, 24'hff_ffff, 24'h00_0001, 24'h80_0000, 24'h7f_ffff};
  always #25 clock = ~clock;
  bctu_core DUT (.clock(clock), .arst_n(arst_n), .clockEnable(1'b1), .instr(instr), .acc(acc), .idx1(idx1),
    .idx2(idx2), .idx3(idx3), .channelIndex(chan), .jumpKeys(keys), .decimalFlags(dflags), .decimalPresent(dPres),
    .decimalEnable(dEn), .multiprogPresent(mpPres), .interruptTaken(irq), .condEvents(events), .result(result),
    .conditionFlags(flags), .lastJumpAddr(lastJump), .interruptHold(hold));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test();
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One request at P=1234, then a bounded wait for completion
  task automatic issue(input logic [23:0] w, input logic [14:0] mm = 15'h0000, input logic ps = 1'b0);
    int k;
    k = 0;
    @(posedge clock);
    instr <= '{1'b1, w, 15'h1234, mm, ps};
    @(posedge clock);
    instr.valid <= 1'b0;
    #1;
    while (result.done !== 1'b1 && k < 4) begin
      @(posedge clock);
      #1;
      k++;
    end
    chk("done", 24'h00_0001, {23'h0, result.done});
  endtask
  task automatic chkJump(input logic t, input logic [14:0] m);
    chk("taken", {23'h0, t}, {23'h0, result.taken});
    chk("target", {9'h0, t ? m : 15'h1235}, {9'h0, result.target});
  endtask
  // Ones-complement step; increment skips minus zero
  function automatic logic [14:0] step(input logic [14:0] v, input logic dn);
    if (dn) return v - 15'h0001;
    return (v == 15'h7ffe) ? 15'h0000 : (v == 15'h7fff) ? 15'h0001 : v + 15'h0001;
  endfunction
  function automatic logic cmpHit(input logic [23:0] a, input logic [1:0] j);
    logic z;
    z = (a == 24'h00_0000) || (a == 24'hff_ffff);
    return (j == 2'h0) ? z : (j == 2'h1) ? !z : (j == 2'h2) ? !a[23] : a[23];
  endfunction
  // Unselected registers hold a decoy so a wrong pick shows
  task automatic doIdx(input logic [1:0] b, input logic dn, input logic [14:0] v);
    @(posedge clock);
    idx1 <= (b == 2'h1) ? v : 15'h0005;
    idx2 <= (b == 2'h2) ? v : 15'h0005;
    idx3 <= (b == 2'h3) ? v : 15'h0005;
    issue({OpIndexJmp, dn, b, 15'h0abc});
    chkJump(b != 2'h0 && v != 15'h0000, 15'h0abc);
    if (b != 2'h0 && v != 15'h0000) chk("idx", {9'h0, step(v, dn)}, {9'h0, result.idxData});
    chk("idxWe", {23'h0, b != 2'h0 && v != 15'h0000}, {23'h0, result.idxWe});
    if (b != 2'h0 && v != 15'h0000) chk("idxSel", {22'h0, b}, {22'h0, result.idxSel});
  endtask
  task automatic doCmp(input logic [23:0] a, input logic [1:0] j);
    @(posedge clock);
    acc <= a;
    issue({OpCompare, 1'b0, j, 15'h0777});
    chkJump(cmpHit(a, j), 15'h0777);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h07af));
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    #1;
    chk("flagsRst", 24'h0, {18'h0, flags});
    chk("holdRst", 24'h0, {8'h0, hold, lastJump});
    for (int c = 0; c < 8; c++) begin
      @(posedge clock);
      chan <= 3'(c);
      issue({OpTransfer, SubChanRead, 12'h000});
      chk("chan", 24'(c), {21'h0, result.accData[2:0]});
    end
    foreach (corner[i]) for (int b = 0; b < 4; b++) begin
      doIdx(2'(b), 1'b0, corner[i]);
      doIdx(2'(b), 1'b1, corner[i]);
    end
    foreach (accCorner[i]) for (int j = 0; j < 4; j++) doCmp(accCorner[i], 2'(j));
    for (int i = 0; i < 40; i++) begin
      doIdx(2'($urandom), 1'($urandom), 15'($urandom));
      doCmp(24'($urandom), 2'($urandom));
    end
    // Pins pass a two-stage synchroniser before use
    repeat (4) begin
      @(posedge clock);
      keys <= 6'($urandom);
      dflags <= 3'($urandom);
      repeat (3) @(posedge clock);
      for (int j = 1; j < 7; j++) begin
        issue({OpJumpKey, 3'(j), 15'h0321});
        chkJump(keys[j-1], 15'h0321);
      end
      for (int v = 0; v < 3; v++) begin
        issue({OpDecimal, 3'(v), 15'h0654});
        chkJump(dflags[v], 15'h0654);
        chk("noTrap", 24'h0, {23'h0, result.trap});
      end
    end
    for (int t = 0; t < 2; t++) begin
      @(posedge clock);
      dPres <= 1'(t);
      dEn <= 1'(!t);
      repeat (3) @(posedge clock);
      issue({OpDecimal, 3'h1, 15'h0654});
      chk("trap", 24'h1, {23'h0, result.trap});
    end
    // Page file: modified write, read back, then option absent
    @(posedge clock);
    acc <= 24'h00_0a5c;
    idx2 <= 15'h0003;
    issue({OpTransfer, SubPageWrite, 12'h805});
    issue({OpTransfer, SubPageWrite, 12'h088});
    chk("page", 24'h000a5c, {12'h0, result.accData[11:0]});
    @(posedge clock);
    mpPres <= 1'b0;
    acc <= 24'h00_0123;
    issue({OpTransfer, SubPageWrite, 12'h008});
    issue({OpTransfer, SubPageWrite, 12'h088});
    chk("pageOff", 24'h0, {23'h0, result.accWe});
    @(posedge clock);
    mpPres <= 1'b1;
    issue({OpTransfer, SubPageWrite, 12'h088});
    chk("pageKept", 24'h000a5c, {12'h0, result.accData[11:0]});
    // Flags: events set, read clears, interrupt hold windows
    @(posedge clock);
    events <= 6'h15;
    @(posedge clock);
    events <= 6'h00;
    irq <= 1'b1;
    @(posedge clock);
    irq <= 1'b0;
    #1;
    chk("holdIrq", 24'h1, {23'h0, hold});
    issue({OpTransfer, SubCondGrp, 12'h000});
    chk("flagRead", 24'h15, {18'h0, result.accData[5:0]});
    @(posedge clock);
    acc <= 24'h00_002a;
    #1;
    chk("flagClr", 24'h0, {17'h0, hold, flags});
    issue({OpTransfer, SubCondGrp, 12'h800});
    @(posedge clock);
    #1;
    chk("flagWr", 24'h6a, {17'h0, hold, flags});
    chk("ljIdle", 24'h0, {9'h0, lastJump});
    issue({OpAlways, 3'h0, 15'h0456}, 15'h0460, 1'b1);
    chkJump(1'b1, 15'h0460);
    @(posedge clock);
    #1;
    chk("lastJump", 24'h001234, {8'h0, hold, lastJump});
    issue({OpTransfer, SubLastJump, 12'h000});
    chk("ljRead", 24'h00_1234, result.accData);
    finish_test();
  end
  // Cuts a hang short
  initial begin
    repeat (8000) @(posedge clock);
    fails++;
    finish_test();
  end
endmodule
